// [hdl/sfid_dev.sv]
// device end: command decode, identity read and power-up gating
`timescale 1ns/1ps
module sfid_dev #(
  parameter int unsigned HOLDOFF_CYC = sfid_pkg::HOLDOFF_CYC_DEF,
  parameter int unsigned BUSY_CYC = sfid_pkg::BUSY_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sfid_if.dev link,
  output logic write_ready,
  output logic deep_sleep,
  output logic [7:0] status
);
  typedef enum logic [2:0] {
    ST_CMD, ST_ARGS, ST_SEND, ST_WAIT, ST_IGNORE
  } sfid_dst_t;

  sfid_dst_t state_ff;
  logic [2:0] sclk_sync_ff;
  logic [2:0] cs_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic sel;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic mosi_q;
  logic [6:0] rx_sr_ff;
  logic [2:0] bit_cnt_ff;
  logic [2:0] byte_cnt_ff;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] cmd_ff;
  logic [7:0] arg_ff;
  logic [7:0] tx_sr_ff;
  logic [2:0] tx_bit_ff;
  logic alt_ff;
  logic miso_ff;
  logic oe_n_ff;
  logic wel_ff;
  logic busy_ff;
  logic sleep_ff;
  logic [5:0] stat_hi_ff;
  logic [15:0] busy_cnt_ff;
  logic [sfid_pkg::HOLD_W-1:0] hold_cnt_ff;
  logic ready_ff;
  logic go_send;
  logic first_alt;
  logic [7:0] send_cmd;
  logic cmd_ok;

  // acceptance of an opcode in the present power state
  function automatic logic accept(input logic [7:0] op, input logic slp,
                                  input logic bsy, input logic rdy);
    logic ok;
    ok = 1'b0;
    if (bsy) begin
      ok = (op == sfid_pkg::OP_RD_STATUS);
    end else if (slp) begin
      ok = (op == sfid_pkg::OP_READ_ID) ||
        (op == sfid_pkg::OP_READ_SIG) || (op == sfid_pkg::OP_WAKE);
    end else if (sfid_pkg::is_write_cmd(op)) begin
      ok = rdy;
    end else begin
      ok = (op == sfid_pkg::OP_READ_ID) || (op == sfid_pkg::OP_READ_SIG) ||
        (op == sfid_pkg::OP_RD_STATUS) || (op == sfid_pkg::OP_READ) ||
        (op == sfid_pkg::OP_SLEEP) || (op == sfid_pkg::OP_CLR_LATCH);
    end
    return ok;
  endfunction

  // byte to send for a read command
  function automatic logic [7:0] tx_byte(input logic [7:0] op,
                                         input logic alt,
                                         input logic [7:0] st);
    logic [7:0] b;
    b = sfid_pkg::ERASED_BYTE;
    if (op == sfid_pkg::OP_READ_ID) begin
      b = alt ? sfid_pkg::PART_CODE : sfid_pkg::MAKER_CODE;
    end else if (op == sfid_pkg::OP_READ_SIG) begin
      b = sfid_pkg::SIG_CODE;
    end else if (op == sfid_pkg::OP_RD_STATUS) begin
      b = st;
    end
    return b;
  endfunction

  // two-stage synchronisers, third stage only for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_ff <= 3'h0;
      cs_sync_ff <= 3'h7;
      mosi_sync_ff <= 2'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], link.sclk};
      cs_sync_ff <= {cs_sync_ff[1:0], link.cs_n};
      mosi_sync_ff <= {mosi_sync_ff[0], link.mosi};
    end
  end

  assign sel = ~cs_sync_ff[1];
  assign cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign mosi_q = mosi_sync_ff[1];
  assign byte_done = sel & sclk_rise & (bit_cnt_ff == 3'h7);
  assign rx_byte = {rx_sr_ff, mosi_q};

  // input shifter, sampled on rising clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
    end else if (!sel) begin
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
    end else if (sclk_rise) begin
      rx_sr_ff <= {rx_sr_ff[5:0], mosi_q};
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7 && byte_cnt_ff != 3'h7) begin
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
      end
    end
  end

  assign cmd_ok = accept(rx_byte, sleep_ff, busy_ff, ready_ff);

  // decision to start sending, and which byte comes first
  always_comb begin
    go_send = 1'b0;
    first_alt = 1'b0;
    send_cmd = cmd_ff;
    if (byte_done && state_ff == ST_CMD) begin
      send_cmd = rx_byte;
      go_send = cmd_ok && (rx_byte == sfid_pkg::OP_RD_STATUS);
    end else if (byte_done && state_ff == ST_ARGS) begin
      go_send = (byte_cnt_ff == sfid_pkg::ARG_BYTES);
      first_alt = (cmd_ff == sfid_pkg::OP_READ_ID) &&
        (rx_byte == sfid_pkg::ID_SWAP_ADDR);
    end
  end

  // command sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_CMD;
      cmd_ff <= 8'h00;
      arg_ff <= 8'h00;
    end else if (!sel) begin
      state_ff <= ST_CMD;
    end else if (byte_done) begin
      unique case (state_ff)
        ST_CMD: begin
          cmd_ff <= rx_byte;
          if (!cmd_ok) begin
            state_ff <= ST_IGNORE;
          end else if (rx_byte == sfid_pkg::OP_READ_ID ||
                       rx_byte == sfid_pkg::OP_READ_SIG ||
                       rx_byte == sfid_pkg::OP_READ) begin
            state_ff <= ST_ARGS;
          end else if (go_send) begin
            state_ff <= ST_SEND;
          end else begin
            state_ff <= ST_WAIT;
          end
        end
        ST_ARGS: begin
          if (go_send) begin
            state_ff <= ST_SEND;
          end
        end
        ST_WAIT: begin
          if (byte_cnt_ff == sfid_pkg::LEN_SHORT) begin // first data byte
            arg_ff <= rx_byte;
          end
        end
        ST_SEND, ST_IGNORE: begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // output shifter, updated on falling clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_sr_ff <= 8'h00;
      tx_bit_ff <= 3'h0;
      alt_ff <= 1'b0;
      miso_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else if (!sel) begin
      tx_bit_ff <= 3'h0;
      oe_n_ff <= 1'b1;
    end else if (go_send) begin
      alt_ff <= first_alt;
      tx_sr_ff <= tx_byte(send_cmd, first_alt, status);
    end else if (state_ff == ST_SEND && sclk_fall) begin
      miso_ff <= tx_sr_ff[7];
      oe_n_ff <= 1'b0;
      tx_bit_ff <= tx_bit_ff + 3'h1;
      if (tx_bit_ff == 3'h7) begin
        alt_ff <= ~alt_ff;
        tx_sr_ff <= tx_byte(cmd_ff, ~alt_ff, status);
      end else begin
        tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
      end
    end
  end

  // hold-off timer after supply-good reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_ff <= '0;
      ready_ff <= 1'b0;
    end else if (!ready_ff) begin
      if (hold_cnt_ff == sfid_pkg::HOLD_W'(HOLDOFF_CYC - 1)) begin
        ready_ff <= 1'b1;
      end else begin
        hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
    end
  end

  // power state, write latch and write cycle execution on deselect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wel_ff <= 1'b0;
      sleep_ff <= 1'b0;
      busy_ff <= 1'b0;
      busy_cnt_ff <= 16'h0000;
      stat_hi_ff <= sfid_pkg::STATUS_RST[7:2];
    end else if (busy_ff) begin
      if (busy_cnt_ff == 16'h0000) begin
        busy_ff <= 1'b0;
        wel_ff <= 1'b0;
      end else begin
        busy_cnt_ff <= busy_cnt_ff - 16'h0001;
      end
    end else if (cs_rise && state_ff == ST_SEND &&
                 cmd_ff == sfid_pkg::OP_READ_SIG) begin
      sleep_ff <= 1'b0;
    end else if (cs_rise && state_ff == ST_WAIT && bit_cnt_ff == 3'h0) begin
      unique case (1'b1)
        cmd_ff == sfid_pkg::OP_SET_LATCH: begin
          if (byte_cnt_ff == sfid_pkg::LEN_SHORT) wel_ff <= 1'b1;
        end
        cmd_ff == sfid_pkg::OP_CLR_LATCH: begin
          if (byte_cnt_ff == sfid_pkg::LEN_SHORT) wel_ff <= 1'b0;
        end
        cmd_ff == sfid_pkg::OP_SLEEP: begin
          if (byte_cnt_ff == sfid_pkg::LEN_SHORT) sleep_ff <= 1'b1;
        end
        cmd_ff == sfid_pkg::OP_PROGRAM ||
        cmd_ff == sfid_pkg::OP_ERASE_SEC ||
        cmd_ff == sfid_pkg::OP_ERASE_CHIP ||
        cmd_ff == sfid_pkg::OP_WR_STATUS: begin
          if (wel_ff && len_ok(cmd_ff, byte_cnt_ff)) begin
            busy_ff <= 1'b1;
            busy_cnt_ff <= 16'(BUSY_CYC - 1);
            if (cmd_ff == sfid_pkg::OP_WR_STATUS) begin
              stat_hi_ff <= arg_ff[7:2];
            end
          end
        end
        default: begin
          sleep_ff <= 1'b0; // wake
        end
      endcase
    end
  end

  // frame length check for write-cycle commands
  function automatic logic len_ok(input logic [7:0] op,
                                  input logic [2:0] n);
    logic ok;
    ok = 1'b0;
    if (op == sfid_pkg::OP_PROGRAM) ok = (n >= sfid_pkg::LEN_PROGRAM);
    if (op == sfid_pkg::OP_ERASE_SEC) ok = (n == sfid_pkg::LEN_ERASE_SEC);
    if (op == sfid_pkg::OP_ERASE_CHIP) ok = (n == sfid_pkg::LEN_SHORT);
    if (op == sfid_pkg::OP_WR_STATUS) ok = (n == sfid_pkg::LEN_WR_STATUS);
    return ok;
  endfunction

  // outputs
  assign status = {stat_hi_ff, wel_ff, busy_ff};
  assign write_ready = ready_ff;
  assign deep_sleep = sleep_ff;
  assign link.miso_o = miso_ff;
  assign link.miso_oe_n = oe_n_ff;
endmodule // sfid_dev

// [shared/sfid_pkg.sv]
// shared constants, command codes and helpers for the identity read block
// Summary of operation
// - select low, 90h, two dummies, address byte
// - identity bits leave on falling clock, MSB first
// - address 01h sends part code first
// - codes alternate while select low and clocking
// - select high stops output, await new command
// - supply below threshold holds logic in reset
// - write-class commands ignored during hold-off delay
// - host sends no writes before both delays
// - plain reads served once select delay passed
// - host keeps select high until supply valid
// - start-up in standby, never deep sleep
// - write latch bit cleared at power-up
// - supply loss disables all command handling
// - identity, signature, wake allowed asleep, not busy
// - status register reads zero after power-up
package sfid_pkg;
  // clock and link timing
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned TPUW_MIN_MS = 1;
  localparam int unsigned TPUW_MAX_MS = 10;
  localparam int unsigned SUPPLY_TO_SELECT_DELAY_US = 30;
  localparam int unsigned TSHSL_NS = 100;
  localparam int unsigned LINK_HALF_NS = 200;
  // cycle counts derived from the times above, except the fixed BUSY_CYC_DEF and the width HOLD_W
  localparam int unsigned HOLDOFF_CYC_DEF =
    (TPUW_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOST_HOLD_CYC_DEF =
    (TPUW_MAX_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SUPPLY_TO_SELECT_DELAY_CYC = (SUPPLY_TO_SELECT_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC = (TSHSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HALF_CYC = LINK_HALF_NS / CLK_NS;
  localparam int unsigned BUSY_CYC_DEF = 64;
  localparam int unsigned HOLD_W = 24;
  // command codes
  localparam logic [7:0] OP_READ_ID = 8'h90;
  localparam logic [7:0] OP_READ_SIG = 8'hAB;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_SEC = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP = 8'hC7;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_READ = 8'h03;
  // identity values, arbitrary neutral codes
  localparam logic [7:0] MAKER_CODE = 8'h5A;
  localparam logic [7:0] PART_CODE = 8'h3C;
  localparam logic [7:0] SIG_CODE = 8'h3C;
  localparam logic [7:0] ID_SWAP_ADDR = 8'h01;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // bytes counted with the opcode at end of a valid frame; ARG_BYTES counts the argument bytes only
  localparam logic [2:0] ARG_BYTES = 3'h3;
  localparam logic [2:0] LEN_SHORT = 3'h1;
  localparam logic [2:0] LEN_WR_STATUS = 3'h2;
  localparam logic [2:0] LEN_ERASE_SEC = 3'h4;
  localparam logic [2:0] LEN_PROGRAM = 3'h5;
  // status field positions
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LATCH_BIT = 1;

  // write-class commands, gated by the hold-off delay
  function automatic logic is_write_cmd(input logic [7:0] op);
    return (op == OP_SET_LATCH) || (op == OP_PROGRAM) ||
      (op == OP_ERASE_SEC) || (op == OP_ERASE_CHIP) ||
      (op == OP_WR_STATUS);
  endfunction
endpackage

// [shared/sfid_if.sv]
// four-wire serial link between host controller and flash device
`timescale 1ns/1ps
interface sfid_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  // line level with a pull-up while the device does not drive
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport dev (
    input cs_n,
    input sclk,
    input mosi,
    output miso_o,
    output miso_oe_n
  );
  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input miso
  );
endinterface

// [hdl/sfid_host.sv]
// host end: serial frame master with power-up select and write gating
`timescale 1ns/1ps
module sfid_host #(
  parameter int unsigned HOST_HOLD_CYC = sfid_pkg::HOST_HOLD_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sfid_if.host link,
  input wire logic start,
  input wire logic [7:0] op,
  input wire logic [23:0] args,
  input wire logic [1:0] n_args,
  input wire logic [3:0] n_rx,
  output logic ready,
  output logic write_ok,
  output logic refused,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic done
);
  typedef enum logic [2:0] {
    H_PWR, H_IDLE, H_LOW, H_HIGH, H_GAP
  } sfid_hst_t;

  sfid_hst_t state_ff;
  logic [1:0] miso_sync_ff;
  logic [31:0] sh_ff;
  logic [6:0] rx_sr_ff;
  logic [7:0] bit_ff;
  logic [7:0] last_ff;
  logic [7:0] txb_ff;
  logic [2:0] ph_ff;
  logic [9:0] cnt_ff;
  logic [sfid_pkg::HOLD_W-1:0] hold_ff;
  logic hold_done_ff;
  logic cs_n_ff;
  logic sclk_ff;
  logic half_end;
  logic take;

  // miso from the pin through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) miso_sync_ff <= 2'h3;
    else miso_sync_ff <= {miso_sync_ff[0], link.miso};
  end

  // write hold-off wait, longest case
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= '0;
      hold_done_ff <= 1'b0;
    end else if (!hold_done_ff) begin
      if (hold_ff == sfid_pkg::HOLD_W'(HOST_HOLD_CYC - 1)) begin
        hold_done_ff <= 1'b1;
      end else begin
        hold_ff <= hold_ff + 1'b1;
      end
    end
  end

  assign ready = (state_ff == H_IDLE);
  assign take = start & ready;
  assign half_end = (ph_ff == 3'(sfid_pkg::HALF_CYC - 1));

  // frame sequencer and clock divider
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= H_PWR;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      sh_ff <= 32'h0000_0000;
      rx_sr_ff <= 7'h00;
      bit_ff <= 8'h00;
      last_ff <= 8'h00;
      txb_ff <= 8'h00;
      ph_ff <= 3'h0;
      cnt_ff <= 10'h000;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      refused <= 1'b0;
      done <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      refused <= 1'b0;
      done <= 1'b0;
      unique case (state_ff)
        H_PWR: begin
          if (cnt_ff == 10'(sfid_pkg::SUPPLY_TO_SELECT_DELAY_CYC - 1)) begin
            state_ff <= H_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 10'h001;
          end
        end
        H_IDLE: begin
          if (take && sfid_pkg::is_write_cmd(op) && !hold_done_ff) begin
            refused <= 1'b1;
          end else if (take) begin
            cs_n_ff <= 1'b0;
            sh_ff <= {op, args};
            bit_ff <= 8'h00;
            txb_ff <= {3'(n_args) + 5'h01, 3'h0};
            last_ff <= {5'(n_args) + 5'(n_rx) + 5'h01, 3'h0} - 8'h01;
            ph_ff <= 3'h0;
            state_ff <= H_LOW;
          end
        end
        H_LOW: begin
          ph_ff <= half_end ? 3'h0 : ph_ff + 3'h1;
          if (half_end) begin
            sclk_ff <= 1'b1;
            state_ff <= H_HIGH;
          end
        end
        H_HIGH: begin
          ph_ff <= half_end ? 3'h0 : ph_ff + 3'h1;
          if (half_end) begin
            sclk_ff <= 1'b0;
            sh_ff <= {sh_ff[30:0], 1'b0};
            rx_sr_ff <= {rx_sr_ff[5:0], miso_sync_ff[1]};
            bit_ff <= bit_ff + 8'h01;
            if (bit_ff >= txb_ff && bit_ff[2:0] == 3'h7) begin
              rx_data <= {rx_sr_ff, miso_sync_ff[1]};
              rx_valid <= 1'b1;
            end
            if (bit_ff == last_ff) begin
              cs_n_ff <= 1'b1;
              cnt_ff <= 10'h000;
              state_ff <= H_GAP;
            end else begin
              state_ff <= H_LOW;
            end
          end
        end
        H_GAP: begin
          if (cnt_ff == 10'(sfid_pkg::GAP_CYC - 1)) begin
            done <= 1'b1;
            state_ff <= H_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 10'h001;
          end
        end
      endcase
    end
  end

  assign write_ok = hold_done_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sclk = sclk_ff;
  assign link.mosi = sh_ff[31];
endmodule // sfid_host

// [test/sfid_link_props.sv]
// assertions on the host-to-device serial link
`timescale 1ns/1ps
module sfid_link_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic miso
);
  logic sclk_q_ff;
  logic [5:0] rise_cnt_ff;
  logic [15:0] since_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // delayed serial clock for edge finding
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= sclk;
    end
  end

  // serial clock rises in the current frame, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_ff <= 6'h00;
    end else if (cs_n) begin
      rise_cnt_ff <= 6'h00;
    end else if (sclk && !sclk_q_ff && rise_cnt_ff != 6'h3F) begin
      rise_cnt_ff <= rise_cnt_ff + 6'h01;
    end
  end

  // cycles since reset release, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      since_ff <= 16'h0000;
    end else if (since_ff != 16'hFFFF) begin
      since_ff <= since_ff + 16'h0001;
    end
  end

  a_sclk_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_out_steady: assert property (
    sclk && $past(sclk) && !miso_oe_n |-> $stable(miso_o) && $stable(miso))
    else $error("device data moved while clock high");
  a_out_after_cmd: assert property (
    $fell(miso_oe_n) |-> rise_cnt_ff >= 6'h08)
    else $error("device drove before a full command byte");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:3] miso_oe_n)
    else $error("device still drives after deselect");
  a_oe_selected: assert property (
    !miso_oe_n |-> !cs_n || !$past(cs_n) || !$past(cs_n, 2) ||
      !$past(cs_n, 3))
    else $error("device drives while deselected");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> cs_n && miso_oe_n && !sclk)
    else $error("link active straight out of reset");
  a_select_wait: assert property (
    !cs_n |-> since_ff >= 16'(sfid_pkg::SUPPLY_TO_SELECT_DELAY_CYC))
    else $error("select taken before power-up delay");
  a_idle_clock_low: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock high outside frame");

  // main scenarios
  c_output: cover property ($fell(miso_oe_n));
  c_long_frame: cover property (rise_cnt_ff >= 6'h20 && !miso_oe_n);
  c_restart: cover property ($rose(rst_n));
endmodule // sfid_link_props

// [test/sfid_test.sv]
// self-checking bench: host and device ends joined on one link
`timescale 1ns/1ps
module sfid_test;
  typedef struct {
    logic [7:0] o;
    logic [23:0] a;
    logic [1:0] na;
    logic [3:0] nr;
    logic [31:0] ex;
  } sfid_row_t;
  localparam logic [7:0] MK = sfid_pkg::MAKER_CODE;
  localparam logic [7:0] PT = sfid_pkg::PART_CODE;
  localparam logic [7:0] SG = sfid_pkg::SIG_CODE;
  localparam logic [7:0] ER = sfid_pkg::ERASED_BYTE;
  localparam logic [7:0] RID = sfid_pkg::OP_READ_ID;
  logic clk_sys, rst_n, start, seen, cs_low;
  logic [7:0] op, rx_data, status, st2;
  logic [23:0] args;
  logic [1:0] n_args;
  logic [3:0] n_rx;
  logic ready, write_ok, refused, rx_valid, done, write_ready, deep_sleep;
  logic wr2;
  int err_total, num_checks, w;
  sfid_row_t rows [7];
  sfid_row_t r;
  sfid_if link ();
  sfid_if bus2 ();

  sfid_host #(.HOST_HOLD_CYC(5100)) sfid_host_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .link(link), .start(start), .op(op), .args(args),
    .n_args(n_args), .n_rx(n_rx), .ready(ready), .write_ok(write_ok),
    .refused(refused), .rx_data(rx_data), .rx_valid(rx_valid), .done(done));
  sfid_dev #(.HOLDOFF_CYC(5000)) sfid_dev_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .link(link), .write_ready(write_ready),
    .deep_sleep(deep_sleep), .status(status));
  // second device, driven directly by the bench
  sfid_dev #(.HOLDOFF_CYC(1000)) sfid_dev_b_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .link(bus2), .write_ready(wr2), .deep_sleep(),
    .status(st2));
  sfid_link_props sfid_link_props_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
    .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n), .miso(link.miso));

  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t ns: %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one host frame, received bytes compared in order
  task automatic frame(input logic [7:0] o, input logic [23:0] a,
    input logic [1:0] na, input logic [3:0] nr, input logic [31:0] ex);
    int k;
    int t;
    k = 0;
    t = 0;
    while (ready !== 1'b1 && t < 9000) begin
      @(negedge clk_sys);
      t++;
    end
    op = o;
    args = a;
    n_args = na;
    n_rx = nr;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      if (rx_valid === 1'b1 && k < 4) begin
        check(rx_data === ex[31 - 8 * k -: 8], "received byte wrong");
        k++;
      end
      @(negedge clk_sys);
      t++;
    end
    check(done === 1'b1, "frame never ended");
    check(k == int'(nr), "received byte count wrong");
  endtask

  // one command byte bit-banged to the second device
  task automatic bb_cmd(input logic [7:0] b);
    @(negedge clk_sys);
    bus2.cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bus2.mosi = b[i];
      repeat (4) @(negedge clk_sys);
      bus2.sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      bus2.sclk = 1'b0;
    end
    repeat (2) @(negedge clk_sys);
    bus2.cs_n = 1'b1;
    bus2.mosi = ~b[0];
    repeat (6) @(negedge clk_sys);
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("Error at %0t ns: run timed out", $time);
    tally_and_finish();
  end

  initial begin
    {start, op, args, n_args, n_rx, rst_n} = '0;
    {err_total, num_checks} = '0;
    bus2.cs_n = 1'b1;
    bus2.sclk = 1'b0;
    bus2.mosi = 1'b0;
    rows = '{
      '{sfid_pkg::OP_READ, 24'h000010, 2'h3, 4'h2, {ER, ER, 16'h0000}},
      '{sfid_pkg::OP_READ_ID, 24'h000000, 2'h3, 4'h4, {MK, PT, MK, PT}},
      '{sfid_pkg::OP_READ_ID, 24'h000001, 2'h3, 4'h4, {PT, MK, PT, MK}},
      '{sfid_pkg::OP_READ_ID, 24'hA5C302, 2'h3, 4'h4, {MK, PT, MK, PT}},
      '{sfid_pkg::OP_READ_ID, 24'hFF3301, 2'h3, 4'h4, {PT, MK, PT, MK}},
      '{sfid_pkg::OP_RD_STATUS, 24'h000000, 2'h0, 4'h2, 32'h0000_0000},
      '{sfid_pkg::OP_READ_SIG, 24'h000000, 2'h3, 4'h2, {SG, SG, 16'h0000}}};
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    check(deep_sleep === 1'b0, "came up asleep");
    check(status === 8'h00, "status not clear at power-up");
    // write latch request during hold-off is ignored, select after delay
    repeat (sfid_pkg::SUPPLY_TO_SELECT_DELAY_CYC) @(negedge clk_sys);
    bb_cmd(sfid_pkg::OP_SET_LATCH);
    check(wr2 === 1'b0, "second hold-off over too soon");
    check(st2[1] === 1'b0, "latch set during hold-off");
    w = 0;
    while (wr2 !== 1'b1 && w < 1000) begin
      @(negedge clk_sys);
      w++;
    end
    bb_cmd(sfid_pkg::OP_SET_LATCH);
    check(st2[1] === 1'b1, "latch not set after hold-off");
    foreach (rows[i]) begin
      r = rows[i];
      frame(r.o, r.a, r.na, r.nr, r.ex);
    end
    check(write_ready === 1'b0, "hold-off over too soon");
    // write-class request before host hold-off is refused
    op = sfid_pkg::OP_SET_LATCH;
    n_args = 2'h0;
    n_rx = 4'h0;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    {seen, cs_low} = 2'b00;
    repeat (3) begin
      seen = seen | refused;
      cs_low = cs_low | ~link.cs_n;
      @(negedge clk_sys);
    end
    check(seen === 1'b1 && cs_low === 1'b0, "early write not refused");
    w = 0;
    while (write_ok !== 1'b1 && w < 5000) begin
      @(negedge clk_sys);
      w++;
    end
    check(write_ready === 1'b1, "device hold-off not over");
    check(write_ok === 1'b1, "host hold-off not over");
    frame(sfid_pkg::OP_SET_LATCH, 24'h000000, 2'h0, 4'h0, 32'h0);
    frame(sfid_pkg::OP_RD_STATUS, 24'h0, 2'h0, 4'h1, 32'h0200_0000);
    // status write runs a write cycle, latch cleared at its end
    frame(sfid_pkg::OP_WR_STATUS, 24'h800000, 2'h1, 4'h0, 32'h0);
    repeat (2) @(negedge clk_sys);
    check(status === 8'h83, "write cycle not started");
    repeat (70) @(negedge clk_sys);
    check(status === 8'h80, "write cycle did not end");
    // deep sleep: identity served, status refused, signature wakes
    frame(sfid_pkg::OP_SLEEP, 24'h000000, 2'h0, 4'h0, 32'h0);
    repeat (2) @(negedge clk_sys);
    check(deep_sleep === 1'b1, "sleep not entered");
    frame(sfid_pkg::OP_RD_STATUS, 24'h0, 2'h0, 4'h1, {ER, 24'h0});
    frame(RID, 24'h000001, 2'h3, 4'h2, {PT, MK, 16'h0});
    frame(sfid_pkg::OP_READ_SIG, 24'h0, 2'h3, 4'h1, {SG, 24'h0});
    repeat (2) @(negedge clk_sys);
    check(deep_sleep === 1'b0, "signature read did not wake");
    // supply loss in mid-frame
    op = sfid_pkg::OP_READ_ID;
    args = 24'h000000;
    n_args = 2'h3;
    n_rx = 4'h4;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (300) @(negedge clk_sys);
    check(link.miso_oe_n === 1'b0, "device not driving codes");
    check(ready === 1'b0, "host idle during frame");
    rst_n = 1'b0;
    @(negedge clk_sys);
    check(link.miso_oe_n === 1'b1, "still driving");
    check(status === 8'h00, "status kept");
    check(write_ready === 1'b0 && write_ok === 1'b0, "gate kept");
    check(deep_sleep === 1'b0 && ready === 1'b0, "not idle");
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    frame(RID, 24'h0, 2'h3, 4'h2, {MK, PT, 16'h0});
    tally_and_finish();
  end
endmodule // sfid_test
